//--- pcsia_regs.svh
`ifndef PCSIA_REGS_SVH
`define PCSIA_REGS_SVH

// ----------------------------------------------------------------------
// Widths and depths
// ----------------------------------------------------------------------
`define PCSIA_PC_W 13
`define PCSIA_LATCH_W 5
`define PCSIA_PAGE_ADDR_W 11
`define PCSIA_STACK_DEPTH 8

// ----------------------------------------------------------------------
// Register file offsets (low seven address bits, mirrored in all four banks)
// ----------------------------------------------------------------------
`define PCSIA_ADDR_INDIRECT 7'h00
`define PCSIA_ADDR_PC_LOW 7'h02
`define PCSIA_ADDR_POINTER 7'h04
`define PCSIA_ADDR_LATCH 7'h0A

// ----------------------------------------------------------------------
// Reset values and vectors
// ----------------------------------------------------------------------
`define PCSIA_RESET_VECTOR 13'h0000
`define PCSIA_IRQ_VECTOR 13'h0004
`define PCSIA_LATCH_RST 5'h00
`define PCSIA_POINTER_RST 8'h00
`define PCSIA_INDIRECT_SELF_READ 8'h00

`endif

//--- pcsia_pkg.sv
package pcsia_pkg;

  // Which register a data access lands on
  typedef enum logic [2:0] {
    PCSIA_SEL_INDIRECT,
    PCSIA_SEL_PC_LOW,
    PCSIA_SEL_POINTER,
    PCSIA_SEL_LATCH,
    PCSIA_SEL_MEMORY
  } pcsia_sel_e;

endpackage

//--- pcsia_stack_if.sv
`timescale 1ns/1ps
`include "pcsia_regs.svh"

interface pcsia_stack_if;
  logic push;
  logic pop;
  logic [`PCSIA_PC_W-1:0] push_data;
  logic [`PCSIA_PC_W-1:0] top_data;

  modport core (output push, output pop, output push_data, input top_data);
  modport stack (input push, input pop, input push_data, output top_data);
endinterface

//--- pcsia_stack.sv
`timescale 1ns/1ps
`include "pcsia_regs.svh"

module pcsia_stack import pcsia_pkg::*; #(
  parameter int DEPTH = `PCSIA_STACK_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  pcsia_stack_if.stack sp
);
  localparam int PW = $clog2(DEPTH);

  logic [`PCSIA_PC_W-1:0] entry [DEPTH];
  logic [PW-1:0] ptr;

  // ----------------------------------------------------------------------
  // Circular storage; the pointer has no port, software cannot see it
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr <= '0;
    end else if (sp.push) begin
      ptr <= PW'(ptr + 1'b1);
    end else if (sp.pop) begin
      ptr <= PW'(ptr - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        entry[i] <= '0;
      end
    end else if (sp.push) begin
      entry[ptr] <= sp.push_data;
    end
  end

  // Empty pop simply reads the slot below the wrapped pointer
  assign sp.top_data = entry[PW'(ptr - 1'b1)];

  chk_stack_push_wrap: assert property (
    @(posedge clk) disable iff (!rst_b)
    sp.push |=> ptr == PW'($past(ptr) + 1'b1))
    else $error("stack pointer did not advance circularly on push");
  chk_stack_pop_data: assert property (
    @(posedge clk) disable iff (!rst_b)
    sp.push ##1 (sp.pop && !sp.push) |-> sp.top_data == $past(sp.push_data))
    else $error("pop did not return the entry just pushed");
  cov_stack_wrap: cover property (@(posedge clk) disable iff (!rst_b)
    sp.push && ptr == PW'(DEPTH - 1));
endmodule

//--- pcsia_core.sv
`timescale 1ns/1ps
`include "pcsia_regs.svh"

// Behaviour
// - 13-bit counter addresses next fetch
// - Counter low byte readable and writable
// - Upper counter bits loaded only via latch
// - Eight-entry hidden return stack, pointer inaccessible
// - Call or interrupt branch pushes counter
// - Return variants pop stack into counter
// - Push and pop leave latch unchanged
// - Ninth push overwrites oldest, circularly, silently
// - Jumps take 11 bits, page from latch
// - Return restores all 13 counter bits
// - Virtual register accesses pointer-addressed register
// - Pointer zero virtual read returns zero
// - Virtual write onto itself stores nothing
// - Indirect address is bank bit over pointer
// - Bank bit unused unless USE_BANK_BIT set; pointer alone selects
module pcsia_core import pcsia_pkg::*; #(
  parameter bit USE_BANK_BIT = 1'b0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pc_advance,
  input wire logic goto_en,
  input wire logic call_en,
  input wire logic irq_branch,
  input wire logic ret_en,
  input wire logic [`PCSIA_PAGE_ADDR_W-1:0] branch_addr,
  input wire logic fa_valid,
  input wire logic fa_write,
  input wire logic [8:0] fa_addr,
  input wire logic [7:0] fa_wdata,
  input wire logic indirect_bank_bit,
  output logic [`PCSIA_PC_W-1:0] program_counter,
  output logic [`PCSIA_LATCH_W-1:0] pc_upper_latch,
  output logic [7:0] indirect_pointer,
  output logic dm_rd_en,
  output logic dm_wr_en,
  output logic [8:0] dm_addr,
  output logic [7:0] dm_wdata,
  output logic rd_valid,
  output logic [7:0] rd_data
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic pcsia_sel_e reg_decode(input logic [6:0] a);
    if (a == `PCSIA_ADDR_INDIRECT) begin
      reg_decode = PCSIA_SEL_INDIRECT;
    end else if (a == `PCSIA_ADDR_PC_LOW) begin
      reg_decode = PCSIA_SEL_PC_LOW;
    end else if (a == `PCSIA_ADDR_POINTER) begin
      reg_decode = PCSIA_SEL_POINTER;
    end else if (a == `PCSIA_ADDR_LATCH) begin
      reg_decode = PCSIA_SEL_LATCH;
    end else begin
      reg_decode = PCSIA_SEL_MEMORY;
    end
  endfunction

  pcsia_sel_e acc_sel;
  logic [8:0] eff_addr;
  logic [8:0] tgt_addr;
  logic acc_rd;
  logic acc_wr;

  always_comb begin
    // Bank bit kept out of the address unless the parameter asks for it
    eff_addr = USE_BANK_BIT ? {indirect_bank_bit, indirect_pointer}
                            : {1'b0, indirect_pointer};
    acc_sel = reg_decode(fa_addr[6:0]);
    tgt_addr = fa_addr;
    if (acc_sel == PCSIA_SEL_INDIRECT) begin
      // Second decode: what remains INDIRECT here is a self access
      acc_sel = reg_decode(eff_addr[6:0]);
      tgt_addr = eff_addr;
    end
  end

  assign acc_rd = fa_valid && !fa_write;
  assign acc_wr = fa_valid && fa_write;

  // ----------------------------------------------------------------------
  // Return stack
  // ----------------------------------------------------------------------
  pcsia_stack_if stk();

  pcsia_stack #(.DEPTH(`PCSIA_STACK_DEPTH)) u_stack (
    .clk(clk),
    .rst_b(rst_b),
    .sp(stk.stack)
  );

  assign stk.push = call_en || irq_branch;
  // A jump in the same cycle outranks the return, so nothing is popped
  assign stk.pop = ret_en && !stk.push && !goto_en;
  assign stk.push_data = program_counter;

  // ----------------------------------------------------------------------
  // Program counter; branches outrank register writes and advance
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      program_counter <= `PCSIA_RESET_VECTOR;
    end else if (irq_branch) begin
      program_counter <= `PCSIA_IRQ_VECTOR;
    end else if (call_en || goto_en) begin
      // Two latch bits cover a full 13-bit space; bits 4:3 select the 2K page
      program_counter <= {pc_upper_latch[4:3], branch_addr};
    end else if (ret_en) begin
      program_counter <= stk.top_data;
    end else if (acc_wr && acc_sel == PCSIA_SEL_PC_LOW) begin
      program_counter <= {pc_upper_latch, fa_wdata};
    end else if (pc_advance) begin
      program_counter <= `PCSIA_PC_W'(program_counter + 1'b1);
    end
  end

  // ----------------------------------------------------------------------
  // Latch and pointer; stack traffic never touches the latch
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_upper_latch <= `PCSIA_LATCH_RST;
    end else if (acc_wr && acc_sel == PCSIA_SEL_LATCH) begin
      pc_upper_latch <= fa_wdata[`PCSIA_LATCH_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      indirect_pointer <= `PCSIA_POINTER_RST;
    end else if (acc_wr && acc_sel == PCSIA_SEL_POINTER) begin
      indirect_pointer <= fa_wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Data memory request, one cycle after the access
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dm_rd_en <= 1'b0;
      dm_wr_en <= 1'b0;
      dm_addr <= 9'h000;
      dm_wdata <= 8'h00;
    end else begin
      dm_rd_en <= acc_rd && acc_sel == PCSIA_SEL_MEMORY;
      // Self write lands on INDIRECT, never MEMORY, so nothing is stored
      dm_wr_en <= acc_wr && acc_sel == PCSIA_SEL_MEMORY;
      if (fa_valid && acc_sel == PCSIA_SEL_MEMORY) begin
        dm_addr <= tgt_addr;
        dm_wdata <= fa_wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Own register read data
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
    end else begin
      rd_valid <= acc_rd && acc_sel != PCSIA_SEL_MEMORY;
      if (acc_rd) begin
        case (acc_sel)
          PCSIA_SEL_INDIRECT: begin
            rd_data <= `PCSIA_INDIRECT_SELF_READ;
          end
          PCSIA_SEL_PC_LOW: begin
            rd_data <= program_counter[7:0];
          end
          PCSIA_SEL_POINTER: begin
            rd_data <= indirect_pointer;
          end
          PCSIA_SEL_LATCH: begin
            rd_data <= {3'b000, pc_upper_latch};
          end
          default: begin
            rd_data <= 8'h00;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  logic self_ind;
  assign self_ind = fa_valid && fa_addr[6:0] == `PCSIA_ADDR_INDIRECT
                    && indirect_pointer == 8'h00;

  chk_pc_advance_step: assert property (
    pc_advance && !irq_branch && !call_en && !goto_en && !ret_en
    && !(acc_wr && acc_sel == PCSIA_SEL_PC_LOW)
    |=> program_counter == `PCSIA_PC_W'($past(program_counter) + 1'b1))
    else $error("counter did not advance by one");
  chk_pc_low_read: assert property (
    acc_rd && fa_addr[6:0] == `PCSIA_ADDR_PC_LOW
    |=> rd_valid && rd_data == $past(program_counter[7:0]))
    else $error("low byte read returned wrong value");
  chk_low_write_upper: assert property (
    acc_wr && acc_sel == PCSIA_SEL_PC_LOW && !irq_branch && !call_en
    && !goto_en && !ret_en
    |=> program_counter == {$past(pc_upper_latch), $past(fa_wdata)})
    else $error("low byte write did not take upper bits from latch");
  chk_jump_page_bits: assert property (
    (goto_en || call_en) && !irq_branch
    |=> program_counter[10:0] == $past(branch_addr)
        && program_counter[11] == $past(pc_upper_latch[3]))
    else $error("jump target or page bit wrong");
  chk_call_push_ret: assert property (
    call_en && !irq_branch ##1 ret_en && !call_en && !irq_branch && !goto_en
    |=> program_counter == $past(program_counter, 2))
    else $error("return did not restore pushed counter");
  chk_return_full_pc: assert property (
    ret_en && !irq_branch && !call_en && !goto_en
    |=> program_counter == $past(stk.top_data))
    else $error("return did not load all counter bits");
  chk_latch_untouched: assert property (
    (stk.push || stk.pop) && !(acc_wr && acc_sel == PCSIA_SEL_LATCH)
    |=> $stable(pc_upper_latch))
    else $error("stack traffic changed the latch");
  chk_indirect_self_read: assert property (
    self_ind && !fa_write |=> rd_valid && rd_data == 8'h00 && !dm_rd_en)
    else $error("self indirect read not zero");
  chk_indirect_self_write: assert property (
    self_ind && fa_write
    |=> !dm_wr_en && $stable(indirect_pointer) && $stable(pc_upper_latch))
    else $error("self indirect write stored data");
  chk_indirect_mem_addr: assert property (
    acc_rd && fa_addr[6:0] == `PCSIA_ADDR_INDIRECT
    && reg_decode(indirect_pointer[6:0]) == PCSIA_SEL_MEMORY
    |=> dm_rd_en && dm_addr == {USE_BANK_BIT && $past(indirect_bank_bit),
                                $past(indirect_pointer)})
    else $error("indirect address formed wrongly");

  cov_call_return: cover property (call_en ##[1:20] ret_en);
  cov_irq_branch: cover property (irq_branch ##1 program_counter ==
                                  `PCSIA_IRQ_VECTOR);
  cov_indirect_mem: cover property (acc_wr && fa_addr[6:0] ==
                                    `PCSIA_ADDR_INDIRECT ##1 dm_wr_en);
  cov_self_write: cover property (self_ind && fa_write);
endmodule

//--- pcsia_mem_model.sv
`timescale 1ns/1ps

// --------------------------------------------------------------------
// Data register file seen from the core
// --------------------------------------------------------------------
module pcsia_mem_model (
  input wire logic clk,
  input wire logic dm_rd_en,
  input wire logic dm_wr_en,
  input wire logic [8:0] dm_addr,
  input wire logic [7:0] dm_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:511];

  initial mem_rdata = 8'h00;

  always @(posedge clk) begin
    if (dm_wr_en) begin
      mem[dm_addr] <= dm_wdata;
    end
    // Not selected: inverted each idle cycle, so the stale byte comes back every second idle cycle
    if (dm_rd_en) begin
      mem_rdata <= mem[dm_addr];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

//--- tb_top.sv
`timescale 1ns/1ps

module tb_top;
  import pcsia_pkg::*;
  logic clk, rst_b, pc_advance, goto_en, call_en, irq_branch, ret_en;
  logic fa_valid, fa_write, indirect_bank_bit;
  logic [10:0] branch_addr;
  logic [8:0] fa_addr, dm_addr;
  logic [7:0] fa_wdata, indirect_pointer, dm_wdata, rd_data, mem_rdata;
  logic [12:0] program_counter, pc;
  logic [4:0] pc_upper_latch, lat;
  logic dm_rd_en, dm_wr_en, rd_valid;
  logic [12:0] stk [0:7];
  logic [2:0] sp;
  logic [18:0] notes [$];
  logic [18:0] mon_got, mon_want;
  logic [31:0] r;
  logic [7:0] p, d;
  integer mismatches = 0;
  integer n_tests = 0;
  integer seed = 59;

  pcsia_core dut (.clk, .rst_b, .pc_advance, .goto_en, .call_en,
    .irq_branch, .ret_en, .branch_addr, .fa_valid, .fa_write, .fa_addr,
    .fa_wdata, .indirect_bank_bit, .program_counter, .pc_upper_latch,
    .indirect_pointer, .dm_rd_en, .dm_wr_en, .dm_addr, .dm_wdata,
    .rd_valid, .rd_data);

  pcsia_mem_model mem (.clk, .dm_rd_en, .dm_wr_en, .dm_addr, .dm_wdata,
    .mem_rdata);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ------------------------------------------------------------------
  // Compare and report
  // ------------------------------------------------------------------
  task automatic results;
    if (mismatches == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cmp_pc(input logic [12:0] got, input logic [12:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: counter %h, want %h", $time, got, exp);
    end
  endtask

  task automatic cmp_data(input logic [18:0] got, input logic [18:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: data %h, want %h", $time, got, exp);
    end
  endtask

  // Any pulse with no note waiting is itself a mismatch
  always @(negedge clk) begin
    if (rst_b && (rd_valid || dm_rd_en || dm_wr_en)) begin
      mon_got = rd_valid ? {2'd1, 9'h000, rd_data} : dm_wr_en ?
        {2'd3, dm_addr, dm_wdata} : {2'd2, dm_addr, 8'h00};
      mon_want = notes.size() > 0 ? notes.pop_front() : 19'h0_0000;
      cmp_data(mon_got, mon_want);
    end
  end

  // ------------------------------------------------------------------
  // Drivers
  // ------------------------------------------------------------------
  task automatic acc(input logic w, input logic [8:0] a,
                     input logic [7:0] dat, input logic [18:0] exp);
    if (exp !== 19'h0_0000) notes.push_back(exp);
    // Each task drives every request line, so two calls in a row never
    // lower and raise one signal in the same time step
    {irq_branch, call_en, goto_en, ret_en, pc_advance} = 5'h00;
    fa_valid = 1'b1;
    fa_write = w;
    fa_addr = a;
    fa_wdata = dat;
    @(negedge clk);
  endtask

  // op = {irq, call, goto, ret, advance}
  task automatic ctl(input logic [4:0] op, input logic [10:0] a);
    fa_valid = 1'b0;
    {irq_branch, call_en, goto_en, ret_en, pc_advance} = op;
    branch_addr = a;
    @(negedge clk);
    if (op[4] || op[3]) begin
      stk[sp] = pc;
      sp++;
      pc = op[4] ? 13'h0004 : {lat[4:3], a};
    end else if (op[2]) begin
      pc = {lat[4:3], a};
    end else if (op[1]) begin
      sp--;
      pc = stk[sp];
    end else if (op[0]) begin
      pc++;
    end
    cmp_pc(program_counter, pc);
    cmp_data({14'h0000, pc_upper_latch}, {14'h0000, lat});
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial begin
    {pc_advance, goto_en, call_en, irq_branch, ret_en} = 5'h00;
    {fa_valid, fa_write, fa_addr, fa_wdata, branch_addr} = 0;
    indirect_bank_bit = 1'b1;
    rst_b = 1'b0;
    {pc, lat, sp} = 0;
    for (int i = 0; i < 8; i++) stk[i] = 13'h0000;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    cmp_pc(program_counter, 13'h0000);
    ctl(5'b00001, 11'h000);
    lat = 5'h1A;
    acc(1'b1, 9'h00A, {3'h0, lat}, 19'h0_0000);
    ctl(5'b00101, 11'h7F3);
    acc(1'b1, 9'h002, 8'h55, 19'h0_0000);
    pc = {lat, 8'h55};
    cmp_pc(program_counter, pc);
    acc(1'b0, 9'h002, 8'h00, {2'd1, 9'h000, pc[7:0]});
    ctl(5'b10000, 11'h000);
    for (int i = 0; i < 10; i++) begin
      if (i == 5) begin
        lat = 5'h07;
        acc(1'b1, 9'h00A, {3'h0, lat}, 19'h0_0000);
      end
      r = $random(seed);
      ctl(5'b01000, r[10:0]);
    end
    ctl(5'b01010, 11'h123);
    ctl(5'b00110, 11'h2B4);
    for (int i = 0; i < 14; i++) ctl(5'b00010, 11'h000);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      p = 8'h20 + {2'b00, r[5:0]};
      d = r[15:8];
      acc(1'b1, 9'h004, p, 19'h0_0000);
      cmp_data({11'h000, indirect_pointer}, {11'h000, p});
      acc(1'b1, 9'h000, d, {2'd3, 1'b0, p, d});
      acc(1'b0, 9'h000, 8'h00, {2'd2, 1'b0, p, 8'h00});
      fa_valid = 1'b0;
      @(negedge clk);
      cmp_data({11'h000, mem_rdata}, {11'h000, d});
    end
    acc(1'b1, 9'h1A5, 8'h3C, {2'd3, 9'h1A5, 8'h3C});
    acc(1'b1, 9'h004, 8'h00, 19'h0_0000);
    acc(1'b0, 9'h000, 8'h00, {2'd1, 9'h000, 8'h00});
    acc(1'b1, 9'h000, 8'hA5, 19'h0_0000);
    fa_valid = 1'b0;
    @(negedge clk);
    for (int k = 0; k < 20 && notes.size() > 0; k++) @(negedge clk);
    if (notes.size() > 0) begin
      mismatches++;
      $display("mismatch at %0t: result never came", $time);
    end
    rst_b = 1'b0;
    @(negedge clk);
    rst_b = 1'b1;
    cmp_pc(program_counter, 13'h0000);
    cmp_data({14'h0000, pc_upper_latch}, 19'h0_0000);
    results;
  end
endmodule
